/* dmbd_pkg.sv */
// data memory bank decoder package: map constants, carriers, state layouts
// assumes one core clock and a core that marks each access with its page
//
// Summary of operation
// - main addresses 0x00-0x1F hit one special register set in every bank
// - ram 0x20-0x3F differs in banks 0/1; 0x40-0x7F exists once
// - port-config page reached only by its two dedicated move instructions
// - special-function page reached only by its two dedicated move instructions
// - bank bits are ignored on either extra page
// - extra pages are separate spaces with their own address sets
// - main address 0x0 has no storage; it is the pointer window
// - window access goes to the location the pointer selects
// - timer0 read returns the live running count
// - timer0 write replaces the running count
// - timer0 ticks from instruction clock, external pin or low oscillator
// - address 0x2 is pc bits 7:0, reset to 0x00
// - pc advances by one per executed instruction unless loaded
// - pc bits 10:8 come from the high-byte buffer on a low-byte write to 0x2
// - long jump loads all 11 pc bits from the instruction
// - long call loads all 11 pc bits and pushes pc+1
// - indirect access: bank bits pick bank, pointer bits 6:0 location
// - direct access: bank bits pick bank, opcode bits 6:0 location
// - call pushes pc+1, interrupt pushes pc; return pops it into pc
package dmbd_pkg;
  // ************************************************************
  // data memory map
  // ************************************************************
  localparam logic [6:0]  ADDR_WINDOW   = 7'h00;
  localparam logic [6:0]  ADDR_TIMER0   = 7'h01;
  localparam logic [6:0]  ADDR_PCL      = 7'h02;
  localparam logic [6:0]  ADDR_STATUS   = 7'h03;
  localparam logic [6:0]  ADDR_POINTER  = 7'h04;
  localparam logic [6:0]  ADDR_PROGRAM_COUNTER_HIGH_BUFFER   = 7'h0A;
  localparam logic [6:0]  ADDR_GAP_A    = 7'h07;
  localparam logic [6:0]  ADDR_GAP_B    = 7'h0D;
  localparam logic [6:0]  ADDR_GAP_C    = 7'h1D;
  localparam logic [6:0]  ADDR_GAP_D    = 7'h1E;
  localparam logic [6:0]  SFR_TOP       = 7'h1F;
  localparam logic [6:0]  GPR_BASE      = 7'h20;
  localparam logic [6:0]  GPR_LOW_TOP   = 7'h3F;
  localparam logic [6:0]  GPR_BANK1_OFS = 7'h40;
  localparam logic [6:0]  SPAGE_TOP     = 7'h15;
  localparam logic [15:0] FPAGE_MASK    = 16'hD660;
  localparam int          GPR_COUNT     = 128;
  localparam int          SFR_COUNT     = 32;
  localparam int          FPAGE_COUNT   = 16;
  localparam int          SPAGE_COUNT   = 22;
  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int          STAT_BANK_HI  = 7;
  localparam int          STAT_BANK_LO  = 6;
  localparam logic [7:0]  STATUS_RST    = 8'h18;
  localparam logic [7:0]  POINTER_RST   = 8'h00;
  localparam logic [10:0] PC_RST        = 11'h000;
  localparam logic [2:0]  PROGRAM_COUNTER_HIGH_BUFFER_RST    = 3'h0;
  localparam logic [10:0] IRQ_VECTOR    = 11'h008;
  localparam int          STACK_DEPTH   = 8;
  // ************************************************************
  // page and timer source codes
  // ************************************************************
  localparam logic [1:0]  PAGE_MAIN     = 2'h0;
  localparam logic [1:0]  PAGE_PORT     = 2'h1;
  localparam logic [1:0]  PAGE_SPEC     = 2'h2;
  localparam logic        T0_MODE_INST  = 1'h0;
  // ************************************************************
  // carriers and state layouts
  // ************************************************************
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] page;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dmbd_req_type;
  typedef struct packed {
    logic        step;
    logic        jump;
    logic        call;
    logic        ret;
    logic        irq;
    logic [10:0] target;
  } dmbd_flow_type;
  typedef struct packed {
    logic mode;
    logic low_osc_sel;
    logic inst_tick;
    logic ext_clk;
    logic low_osc_tick;
  } dmbd_tsrc_type;
  typedef struct packed {
    logic [7:0] count;
    logic       ext_prev;
  } dmbd_t0_state_type;
  typedef struct packed {
    logic [GPR_COUNT-1:0][7:0]    ram;
    logic [SFR_COUNT-1:0][7:0]    sfr;
    logic [FPAGE_COUNT-1:0][7:0]  fpage;
    logic [SPAGE_COUNT-1:0][7:0]  spage;
    logic [STACK_DEPTH-1:0][10:0] stack;
    logic [2:0]                   sp;
    logic [7:0]                   status;
    logic [7:0]                   pointer;
    logic [2:0]                   program_counter_high_buffer;
    logic [10:0]                  pc;
    logic [7:0]                   rdata;
    logic                         rvalid;
  } dmbd_state_type;
endpackage : dmbd_pkg

/* dmbd_timer0.sv */
// timer0 counter with three tick sources and a load port
// assumes all source inputs are synchronous single-cycle ticks or levels
`timescale 1ns/1ps
`default_nettype none
module dmbd_timer0
  import dmbd_pkg::*;
(
  // clock, reset, freeze
  input  wire logic          clk_in,
  input  wire logic          resetn_in,
  input  wire logic          enable_in,
  // tick sources
  input  wire dmbd_tsrc_type src_in,
  // load from the register path
  input  wire logic          load_in,
  input  wire logic [7:0]    load_data_in,
  // running count
  output logic [7:0]         count_out
);
  dmbd_t0_state_type st_ff;
  dmbd_t0_state_type nxt_st;
  logic              tick;

  // source pick, then load over count
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_prev = src_in.ext_clk;
    if (src_in.mode == T0_MODE_INST) begin
      tick = src_in.inst_tick;
    end else if (src_in.low_osc_sel) begin
      tick = src_in.low_osc_tick;
    end else begin
      tick = src_in.ext_clk && !st_ff.ext_prev;
    end
    if (load_in) begin
      nxt_st.count = load_data_in;
    end else if (tick) begin
      nxt_st.count = st_ff.count + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '0;
    end else if (enable_in) begin
      st_ff <= nxt_st;
    end
  end

  assign count_out = st_ff.count;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  timer_load_a: assert property (enable_in && load_in
    |=> count_out == $past(load_data_in))
    else $error("timer0 did not take the written byte");
  inst_tick_a: assert property (enable_in && !load_in && src_in.mode == T0_MODE_INST
    && src_in.inst_tick |=> count_out == $past(count_out) + 8'h01)
    else $error("timer0 missed an instruction tick");
  inst_hold_a: assert property (enable_in && !load_in && src_in.mode == T0_MODE_INST
    && !src_in.inst_tick |=> $stable(count_out))
    else $error("timer0 moved without a tick");
  ext_edge_a: assert property (enable_in && !load_in && src_in.mode != T0_MODE_INST
    && !src_in.low_osc_sel && src_in.ext_clk && !st_ff.ext_prev
    |=> count_out == $past(count_out) + 8'h01)
    else $error("timer0 missed an external edge");
  low_tick_a: assert property (enable_in && !load_in && src_in.mode != T0_MODE_INST
    && src_in.low_osc_sel && src_in.low_osc_tick
    |=> count_out == $past(count_out) + 8'h01)
    else $error("timer0 missed a low oscillator tick");
  timer_freeze_a: assert property (!enable_in |=> $stable(count_out))
    else $error("timer0 moved while frozen");
endmodule : dmbd_timer0
`default_nettype wire

/* dmbd_core.sv */
// data memory decoder: bank folding, extra pages, pointer window, pc low byte
// assumes the core issues at most one access per cycle and names its page
`timescale 1ns/1ps
`default_nettype none
module dmbd_core
  import dmbd_pkg::*;
(
  // clock, reset, freeze
  input  wire logic          clk_in,
  input  wire logic          resetn_in,
  input  wire logic          enable_in,
  // data access from the core
  input  wire dmbd_req_type  req_in,
  // program flow from the core
  input  wire dmbd_flow_type flow_in,
  // timer0 tick sources
  input  wire dmbd_tsrc_type tsrc_in,
  // read answer
  output logic [7:0]         rdata_out,
  output logic               rvalid_out,
  // program counter
  output logic [10:0]        pc_out
);
  // ************************************************************
  // decode helpers
  // ************************************************************

  // fold a general-purpose address onto physical ram
  function automatic logic [6:0] gpr_index(input logic [1:0] bank, input logic [6:0] addr);
    if (bank[0] && (addr <= GPR_LOW_TOP)) begin
      gpr_index = addr + GPR_BANK1_OFS;
    end else begin
      gpr_index = addr - GPR_BASE;
    end
  endfunction : gpr_index

  // unassigned main-page holes
  function automatic logic main_gap(input logic [6:0] addr);
    main_gap = (addr == ADDR_GAP_A) || (addr == ADDR_GAP_B)
            || (addr == ADDR_GAP_C) || (addr == ADDR_GAP_D);
  endfunction : main_gap

  // port-config page membership
  function automatic logic fpage_has(input logic [6:0] addr);
    fpage_has = (addr[6:4] == 3'h0) && FPAGE_MASK[addr[3:0]];
  endfunction : fpage_has

  // special-function page membership
  function automatic logic spage_has(input logic [6:0] addr);
    spage_has = (addr <= SPAGE_TOP);
  endfunction : spage_has

  // ************************************************************
  // state and timer
  // ************************************************************
  dmbd_state_type st_ff;
  dmbd_state_type nxt_st;
  logic [7:0]     t0_count;
  logic           t0_load;
  logic           pcl_wr;

  // timer0 lives in its own counter
  dmbd_timer0 u_timer0 (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .enable_in    (enable_in),
    .src_in       (tsrc_in),
    .load_in      (t0_load),
    .load_data_in (req_in.wdata),
    .count_out    (t0_count)
  );

  // ************************************************************
  // access and flow
  // ************************************************************

  // address resolve, read mux, writes, pc update
  always_comb begin
    logic [6:0]  eff;
    logic [6:0]  gi;
    logic        null_acc;
    logic        rd;
    logic        wr;
    logic        main_acc;
    logic [7:0]  rv;
    logic [10:0] top;
    nxt_st = st_ff;
    eff = (req_in.addr == ADDR_WINDOW) ? st_ff.pointer[6:0] : req_in.addr;
    null_acc = (eff == ADDR_WINDOW);
    gi = gpr_index(st_ff.status[STAT_BANK_HI:STAT_BANK_LO], eff);
    rd = req_in.valid && !req_in.write;
    wr = req_in.valid && req_in.write;
    main_acc = (req_in.page == PAGE_MAIN) && !null_acc;
    rv = 8'h00;
    t0_load = 1'b0;
    pcl_wr = 1'b0;
    top = st_ff.stack[st_ff.sp - 3'h1];

    // read path; extra pages index by their own address only
    case (req_in.page)
      PAGE_PORT: begin
        if (fpage_has(req_in.addr)) begin
          rv = st_ff.fpage[req_in.addr[3:0]];
        end
      end
      PAGE_SPEC: begin
        if (spage_has(req_in.addr)) begin
          rv = st_ff.spage[req_in.addr[4:0]];
        end
      end
      PAGE_MAIN: begin
        if (null_acc) begin
          rv = 8'h00;
        end else if (eff > SFR_TOP) begin
          rv = st_ff.ram[gi];
        end else begin
          // special registers ignore the bank bits
          case (eff)
            ADDR_TIMER0:  rv = t0_count;
            ADDR_PCL:     rv = st_ff.pc[7:0];
            ADDR_STATUS:  rv = st_ff.status;
            ADDR_POINTER: rv = st_ff.pointer;
            ADDR_PROGRAM_COUNTER_HIGH_BUFFER:  rv = 8'h00;
            default: begin
              rv = main_gap(eff) ? 8'h00 : st_ff.sfr[eff[4:0]];
            end
          endcase
        end
      end
      default: rv = 8'h00;
    endcase
    if (rd) begin
      nxt_st.rdata = rv;
    end
    nxt_st.rvalid = rd;

    // write path
    if (wr) begin
      case (req_in.page)
        PAGE_PORT: begin
          if (fpage_has(req_in.addr)) begin
            nxt_st.fpage[req_in.addr[3:0]] = req_in.wdata;
          end
        end
        PAGE_SPEC: begin
          if (spage_has(req_in.addr)) begin
            nxt_st.spage[req_in.addr[4:0]] = req_in.wdata;
          end
        end
        PAGE_MAIN: begin
          if (main_acc && (eff > SFR_TOP)) begin
            nxt_st.ram[gi] = req_in.wdata;
          end else if (main_acc) begin
            case (eff)
              ADDR_TIMER0:  t0_load = 1'b1;
              ADDR_PCL:     pcl_wr = 1'b1;
              ADDR_STATUS:  nxt_st.status = req_in.wdata;
              ADDR_POINTER: nxt_st.pointer = req_in.wdata;
              ADDR_PROGRAM_COUNTER_HIGH_BUFFER:  nxt_st.program_counter_high_buffer = req_in.wdata[2:0];
              default: begin
                if (!main_gap(eff)) begin
                  nxt_st.sfr[eff[4:0]] = req_in.wdata;
                end
              end
            endcase
          end
        end
        default: ;
      endcase
    end

    // pc: interrupt, long jump or call, return, low-byte write, step
    if (flow_in.irq) begin
      nxt_st.stack[st_ff.sp] = st_ff.pc;
      nxt_st.sp = st_ff.sp + 3'h1;
      nxt_st.pc = IRQ_VECTOR;
    end else if (flow_in.jump || flow_in.call) begin
      if (flow_in.call) begin
        nxt_st.stack[st_ff.sp] = st_ff.pc + 11'h001;
        nxt_st.sp = st_ff.sp + 3'h1;
      end
      nxt_st.pc = flow_in.target;
    end else if (flow_in.ret) begin
      nxt_st.sp = st_ff.sp - 3'h1;
      nxt_st.pc = top;
    end else if (pcl_wr) begin
      nxt_st.pc = {st_ff.program_counter_high_buffer, req_in.wdata};
    end else if (flow_in.step) begin
      nxt_st.pc = st_ff.pc + 11'h001;
    end
  end

  // state register with freeze
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '0;
      st_ff.status <= STATUS_RST;
      st_ff.pointer <= POINTER_RST;
      st_ff.program_counter_high_buffer <= PROGRAM_COUNTER_HIGH_BUFFER_RST;
      st_ff.pc <= PC_RST;
    end else if (enable_in) begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from state
  assign rdata_out  = st_ff.rdata;
  assign rvalid_out = st_ff.rvalid;
  assign pc_out     = st_ff.pc;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // one read on a page at an address
  sequence page_rd(logic [1:0] pg, logic [6:0] a);
    enable_in && req_in.valid && !req_in.write && (req_in.page == pg) && (req_in.addr == a);
  endsequence

  // a clean call and a clean return
  sequence call_s;
    enable_in && flow_in.call && !flow_in.irq;
  endsequence
  sequence ret_s;
    enable_in && flow_in.ret && !flow_in.irq && !flow_in.jump && !flow_in.call;
  endsequence

  gap_read_a: assert property (page_rd(PAGE_MAIN, ADDR_GAP_A)
    |=> rvalid_out && rdata_out == 8'h00)
    else $error("hole at 0x7 did not read zero");
  window_null_a: assert property (page_rd(PAGE_MAIN, ADDR_WINDOW)
    ##0 (st_ff.pointer[6:0] == 7'h00) |=> rvalid_out && rdata_out == 8'h00)
    else $error("window through itself did not read zero");
  window_timer_a: assert property (page_rd(PAGE_MAIN, ADDR_WINDOW)
    ##0 (st_ff.pointer[6:0] == ADDR_TIMER0) |=> rdata_out == $past(t0_count))
    else $error("window read missed the pointed register");
  timer_live_a: assert property (page_rd(PAGE_MAIN, ADDR_TIMER0)
    |=> rdata_out == $past(t0_count))
    else $error("timer0 read was not the running count");
  status_alias_a: assert property (page_rd(PAGE_MAIN, ADDR_STATUS)
    |=> rdata_out == $past(st_ff.status))
    else $error("status read depended on bank");
  fpage_gap_a: assert property (page_rd(PAGE_PORT, 7'h00)
    |=> rvalid_out && rdata_out == 8'h00)
    else $error("empty port-config address did not read zero");
  spage_gap_a: assert property (page_rd(PAGE_SPEC, 7'h16)
    |=> rvalid_out && rdata_out == 8'h00)
    else $error("address above the special page did not read zero");
  program_counter_high_buffer_read_a: assert property (page_rd(PAGE_MAIN, ADDR_PROGRAM_COUNTER_HIGH_BUFFER)
    |=> rvalid_out && rdata_out == 8'h00)
    else $error("high buffer was readable");
  read_answer_a: assert property (enable_in && req_in.valid && !req_in.write
    |=> rvalid_out)
    else $error("read not answered one cycle later");
  pc_step_a: assert property (enable_in && flow_in.step && !flow_in.irq
    && !flow_in.jump && !flow_in.call && !flow_in.ret && !pcl_wr
    |=> pc_out == $past(pc_out) + 11'h001)
    else $error("pc did not advance by one");
  long_jump_a: assert property (enable_in && flow_in.jump && !flow_in.irq
    |=> pc_out == $past(flow_in.target))
    else $error("long jump target not loaded");
  long_call_a: assert property (call_s
    |=> pc_out == $past(flow_in.target))
    else $error("long call target not loaded");
  irq_vector_a: assert property (enable_in && flow_in.irq
    |=> pc_out == IRQ_VECTOR)
    else $error("interrupt did not enter the vector");
  call_return_a: assert property (call_s ##1 ret_s
    |=> pc_out == $past(pc_out, 2) + 11'h001)
    else $error("return did not resume after the call");
  pcl_write_a: assert property (enable_in && pcl_wr && !flow_in.irq
    && !flow_in.jump && !flow_in.call && !flow_in.ret
    |=> pc_out == {$past(st_ff.program_counter_high_buffer), $past(req_in.wdata)})
    else $error("low-byte write did not form the full target");
  freeze_pc_a: assert property (!enable_in |=> $stable(pc_out))
    else $error("pc moved while frozen");
endmodule : dmbd_core
`default_nettype wire

/* dmbd_exec_model.sv */
// partner model: the instruction execution core that drives the decoder
// assumes reads answer on the taking edge itself, one cycle after the request is driven
`timescale 1ns/1ps
`default_nettype none
module dmbd_exec_model
  import dmbd_pkg::*;
(
  // clock
  input  wire logic       clk_in,
  // read answer
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  // requests to the decoder
  output var dmbd_req_type  req_out,
  output var dmbd_flow_type flow_out,
  output var dmbd_tsrc_type tsrc_out
);
  // ************************************************************
  // idle values and driver tasks
  // ************************************************************
  initial begin
    req_out = '0;
    flow_out = '0;
    tsrc_out = '0;
  end

  // one access held over one taking edge, released bus shows inverted values
  task automatic access(input logic wr, input logic [1:0] pg, input logic [6:0] ad,
                        input logic [7:0] wd, output logic [7:0] rd, output logic ok);
    @(posedge clk_in);
    req_out <= '{1'b1, wr, pg, ad, wd};
    @(posedge clk_in);
    req_out <= '{1'b0, ~wr, ~pg, ~ad, ~wd};
    #1;
    ok = (rvalid_in === ~wr);
    rd = rdata_in;
  endtask : access

  // one-cycle pulse on the flow lines
  task automatic flow(input dmbd_flow_type f);
    @(posedge clk_in);
    flow_out <= f;
    @(posedge clk_in);
    flow_out <= '0;
    #1;
  endtask : flow

  // two flow pulses on back-to-back edges
  task automatic flow2(input dmbd_flow_type f, input dmbd_flow_type g);
    @(posedge clk_in);
    flow_out <= f;
    @(posedge clk_in);
    flow_out <= g;
    @(posedge clk_in);
    flow_out <= '0;
    #1;
  endtask : flow2

  // n timer ticks; kind 0 instruction clock, 1 external pin, 2 low oscillator
  task automatic ticks(input int kind, input int n);
    @(posedge clk_in);
    tsrc_out.mode <= (kind != 0);
    tsrc_out.low_osc_sel <= (kind == 2);
    repeat (n) begin
      @(posedge clk_in);
      tsrc_out.inst_tick <= (kind == 0);
      tsrc_out.ext_clk <= (kind == 1);
      tsrc_out.low_osc_tick <= (kind == 2);
      @(posedge clk_in);
      tsrc_out.inst_tick <= 1'b0;
      tsrc_out.ext_clk <= 1'b0;
      tsrc_out.low_osc_tick <= 1'b0;
    end
    repeat (2) @(posedge clk_in);
  endtask : ticks
endmodule : dmbd_exec_model
`default_nettype wire

/* data_memory_bank_decoder_tb_top.sv */
// testbench: map table, program flow, timer0 sources, enable and reset
// assumes the core model drives requests and the bench drives clock, reset, enable
`timescale 1ns/1ps
`default_nettype none
module data_memory_bank_decoder_tb_top;
  import dmbd_pkg::*;
  // ************************************************************
  // signals and instances
  // ************************************************************
  typedef struct packed {
    logic       wr;
    logic [1:0] bank;
    logic [1:0] page;
    logic [6:0] addr;
    logic [7:0] data;
  } dmbd_row_type;
  logic          clk_in;
  logic          resetn_in;
  logic          enable_in;
  dmbd_req_type  req;
  dmbd_flow_type flow;
  dmbd_tsrc_type tsrc;
  logic [7:0]    rdata;
  logic          rvalid;
  logic [10:0]   pc;
  logic [7:0]    rd;
  logic          ok;
  int            mismatches;
  int            samples_checked;
  localparam int NROW = 32;
  localparam dmbd_row_type ROWS [NROW] = '{
    '{1'b1, 2'h0, 2'h0, 7'h25, 8'h11}, '{1'b1, 2'h1, 2'h0, 7'h25, 8'h22},
    '{1'b0, 2'h2, 2'h0, 7'h25, 8'h11}, '{1'b0, 2'h3, 2'h0, 7'h25, 8'h22},
    '{1'b1, 2'h0, 2'h0, 7'h50, 8'h33}, '{1'b0, 2'h3, 2'h0, 7'h50, 8'h33},
    '{1'b1, 2'h2, 2'h0, 7'h08, 8'h44}, '{1'b0, 2'h1, 2'h0, 7'h08, 8'h44},
    '{1'b1, 2'h0, 2'h1, 7'h05, 8'h55}, '{1'b0, 2'h3, 2'h1, 7'h05, 8'h55},
    '{1'b0, 2'h0, 2'h0, 7'h05, 8'h00},
    '{1'b1, 2'h1, 2'h2, 7'h05, 8'h66}, '{1'b0, 2'h2, 2'h2, 7'h05, 8'h66},
    '{1'b0, 2'h0, 2'h1, 7'h05, 8'h55},
    '{1'b1, 2'h0, 2'h1, 7'h07, 8'h77}, '{1'b0, 2'h0, 2'h1, 7'h07, 8'h00},
    '{1'b1, 2'h0, 2'h2, 7'h16, 8'h88}, '{1'b0, 2'h0, 2'h2, 7'h16, 8'h00},
    '{1'b1, 2'h0, 2'h0, 7'h0D, 8'h99}, '{1'b0, 2'h0, 2'h0, 7'h0D, 8'h00},
    '{1'b1, 2'h0, 2'h0, 7'h04, 8'h25}, '{1'b0, 2'h0, 2'h0, 7'h00, 8'h11},
    '{1'b0, 2'h1, 2'h0, 7'h00, 8'h22},
    '{1'b1, 2'h1, 2'h0, 7'h00, 8'hAB}, '{1'b0, 2'h3, 2'h0, 7'h25, 8'hAB},
    '{1'b1, 2'h0, 2'h0, 7'h04, 8'h80}, '{1'b0, 2'h0, 2'h0, 7'h00, 8'h00},
    '{1'b1, 2'h0, 2'h0, 7'h0A, 8'h05}, '{1'b0, 2'h0, 2'h0, 7'h0A, 8'h00},
    '{1'b1, 2'h0, 2'h1, 7'h00, 8'h5A}, '{1'b0, 2'h0, 2'h1, 7'h00, 8'h00},
    '{1'b0, 2'h0, 2'h3, 7'h05, 8'h00}};

  dmbd_core u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .enable_in(enable_in),
    .req_in(req), .flow_in(flow), .tsrc_in(tsrc), .rdata_out(rdata),
    .rvalid_out(rvalid), .pc_out(pc));
  dmbd_exec_model u_model (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
    .req_out(req), .flow_out(flow), .tsrc_out(tsrc));

  // ************************************************************
  // compare and driver tasks
  // ************************************************************
  task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t data got %h expected %h", $time, got, exp);
    end
  endtask : check_data

  task automatic check_pc(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t pc got %h expected %h", $time, got, exp);
    end
  endtask : check_pc

  // access with answer timing check; reads compare against d
  task automatic acc(input logic wr, input logic [1:0] pg, input logic [6:0] ad,
                     input logic [7:0] d);
    u_model.access(wr, pg, ad, d, rd, ok);
    check_data({7'h00, ok}, 8'h01);
    if (!wr) check_data(rd, d);
  endtask : acc

  // flow pulse, kind bits are step jump call ret irq
  task automatic fl(input logic [4:0] k, input logic [10:0] t, input logic [10:0] exp);
    u_model.flow({k, t});
    check_pc(pc, exp);
  endtask : fl

  task automatic test_done;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // ************************************************************
  // clock, watchdog, main sequence
  // ************************************************************
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // hang guard
  initial begin
    #(25 * 20000);
    mismatches++;
    test_done();
  end

  initial begin
    mismatches = 0;
    samples_checked = 0;
    resetn_in = 1'b0;
    enable_in = 1'b1;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1;
    check_pc(pc, 11'h000);
    // map table, bank set through status before each row
    for (int i = 0; i < NROW; i++) begin
      acc(1'b1, PAGE_MAIN, ADDR_STATUS, {ROWS[i].bank, 6'h18});
      acc(ROWS[i].wr, ROWS[i].page, ROWS[i].addr, ROWS[i].data);
    end
    // steps, frozen step, low-byte write with buffer, long jump/call, irq, returns
    for (int s = 1; s <= 3; s++) fl(5'h10, 11'h000, 11'(s));
    @(posedge clk_in);
    enable_in <= 1'b0;
    fl(5'h10, 11'h000, 11'h003);
    @(posedge clk_in);
    enable_in <= 1'b1;
    acc(1'b1, PAGE_MAIN, ADDR_PCL, 8'h34);
    check_pc(pc, 11'h534);
    acc(1'b0, PAGE_MAIN, ADDR_PCL, 8'h34);
    fl(5'h08, 11'h7FF, 11'h7FF);
    fl(5'h04, 11'h123, 11'h123);
    fl(5'h01, 11'h000, IRQ_VECTOR);
    fl(5'h02, 11'h000, 11'h123);
    fl(5'h02, 11'h000, 11'h000);
    // call and return on back-to-back edges
    u_model.flow2({5'h04, 11'h250}, {5'h02, 11'h000});
    check_pc(pc, 11'h001);
    // timer0 load, wrap and the three sources
    acc(1'b1, PAGE_MAIN, ADDR_TIMER0, 8'hFE);
    u_model.ticks(0, 3);
    acc(1'b0, PAGE_MAIN, ADDR_TIMER0, 8'h01);
    u_model.ticks(1, 2);
    acc(1'b0, PAGE_MAIN, ADDR_TIMER0, 8'h03);
    u_model.ticks(2, 1);
    acc(1'b0, PAGE_MAIN, ADDR_TIMER0, 8'h04);
    // timer0 seen through the pointer window
    acc(1'b1, PAGE_MAIN, ADDR_POINTER, {1'b0, ADDR_TIMER0});
    acc(1'b0, PAGE_MAIN, ADDR_WINDOW, 8'h04);
    // reset in mid-run
    @(posedge clk_in);
    resetn_in <= 1'b0;
    #1;
    check_pc(pc, 11'h000);
    check_data(rdata, 8'h00);
    check_data({7'h00, rvalid}, 8'h00);
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    acc(1'b0, PAGE_MAIN, ADDR_STATUS, STATUS_RST);
    acc(1'b0, PAGE_MAIN, ADDR_POINTER, POINTER_RST);
    acc(1'b0, PAGE_MAIN, ADDR_TIMER0, 8'h00);
    test_done();
  end
endmodule : data_memory_bank_decoder_tb_top
`default_nettype wire
